// ==== verilog/dual_comparator_control.sv ====
// Control and status logic around two analog comparators, APB slave
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cmp_defs.svh"

// Operation
// - Comparator high when positive exceeds negative
// - Bit 7 shows comparator two, bit 5 inverts
// - Bit 6 shows comparator one, bit 4 inverts
// - Result bits read-only, other six writable
// - Mode 110 switch picks negative input lines
// - Bits 2 to 0 select one of eight modes
// - Mode 110 puts reference on positive inputs
// - Mode 111 powers both comparators off
// - Reset clears control, mode 000, comparators off
// - Output change in modes 001 to 110 sets the change flag
// - Flag stays set until software writes zero
// - Comparators run in sleep, enabled change wakes
// - Wake from sleep keeps control register
// - Routing drives port E lines with unsynchronised, polarity-inverted outputs
// - Port E direction still gates routed drivers
// - Analog-configured port pins read as zero
module dual_comparator_control #(
    parameter int ADDR_W = 8
) (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog comparator cells
    input wire logic cmp_one_raw,
    input wire logic cmp_two_raw,
    output logic cmp_one_power,
    output logic cmp_two_power,
    output logic ref_to_positive,
    output logic negative_input_switch,
    // Port D lines 0 to 3
    input wire logic [3:0] port_d_pins,
    output logic [3:0] port_d_analog,
    // Port E lines 1 and 2
    output logic [1:0] port_e_out,
    output logic [1:0] port_e_oe,
    // Wake and interrupt request
    output logic cmp_wake_irq
);

    typedef struct packed {
        logic [5:0] ctrl;
        logic flag;
        logic irq_en;
        logic route_en;
        logic [1:0] pe_dir;
        logic [1:0] pe_lat;
        logic [1:0] oe;
        logic [3:0] pd_s1;
        logic [3:0] pd_s2;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic pwr_one;
        logic pwr_two;
        logic ref_pos;
        logic neg_sw;
        logic [3:0] analog;
        logic wake;
    } top_state_type;

    top_state_type state_ff;
    top_state_type nxt_state;
    logic res_one;
    logic res_two;
    logic chg_one;
    logic chg_two;
    logic comps_active;
    logic [1:0] routed;

    // Address decode shared by read mux and write path
    function automatic logic [1:0] decode(input logic [ADDR_W-1:0] a);
        if (a == ADDR_W'(`CMP_OFS_CONTROL)) begin
            decode = 2'h1;
        end else if (a == ADDR_W'(`CMP_OFS_FLAGS)) begin
            decode = 2'h2;
        end else if (a == ADDR_W'(`CMP_OFS_PORT)) begin
            decode = 2'h3;
        end else begin
            decode = 2'h0;
        end
    endfunction

    function automatic logic [7:0] control_word(input top_state_type s,
                                                input logic r1,
                                                input logic r2);
        control_word = {r2, r1, s.ctrl};
    endfunction

    cmp_pkg::cmp_mode_type mode;
    assign mode = cmp_pkg::cmp_mode_type'(
        state_ff.ctrl[`CMP_MODE_MSB:`CMP_MODE_LSB]);

    // Outputs from the analog cell are high when positive exceeds negative
    assign comps_active = (mode != cmp_pkg::MODE_OFF)
        && (mode != cmp_pkg::MODE_RESET);

    cmp_sync_chan u_chan_one (
        .pclk(pclk),
        .presetn(presetn),
        .raw_out(cmp_one_raw),
        .polarity(state_ff.ctrl[`CMP_BIT_ONE_POL]),
        .active(comps_active),
        .result(res_one),
        .change(chg_one)
    );

    cmp_sync_chan u_chan_two (
        .pclk(pclk),
        .presetn(presetn),
        .raw_out(cmp_two_raw),
        .polarity(state_ff.ctrl[`CMP_BIT_TWO_POL]),
        .active(comps_active),
        .result(res_two),
        .change(chg_two)
    );

    // Routed pins carry the unsynchronised level, so a glitch passes through
    assign routed = {cmp_two_raw ^ state_ff.ctrl[`CMP_BIT_TWO_POL],
                     cmp_one_raw ^ state_ff.ctrl[`CMP_BIT_ONE_POL]};

    always_comb begin
        logic [1:0] sel;
        logic wr;
        logic rd_setup;
        logic [5:0] next_ctrl;
        cmp_pkg::cmp_mode_type next_mode;
        sel = decode(paddr);
        wr = psel && penable && state_ff.ready && pwrite;
        rd_setup = psel && !penable;
        next_ctrl = '0;
        next_mode = cmp_pkg::MODE_RESET;
        nxt_state = state_ff;
        nxt_state.pd_s1 = port_d_pins;
        nxt_state.pd_s2 = state_ff.pd_s1;
        // Answer one cycle after setup, no wait states
        nxt_state.ready = rd_setup;
        nxt_state.err = rd_setup && (sel == 2'h0);
        nxt_state.rdata = '0;
        if (rd_setup && !pwrite) begin
            if (sel == 2'h1) begin
                nxt_state.rdata = {24'h0, control_word(state_ff, res_one,
                                                       res_two)};
            end else if (sel == 2'h2) begin
                nxt_state.rdata[`CMP_BIT_FLAG] = state_ff.flag;
                nxt_state.rdata[`CMP_BIT_IRQ_EN] = state_ff.irq_en;
                nxt_state.rdata[`CMP_BIT_ROUTE_EN] = state_ff.route_en;
            end else if (sel == 2'h3) begin
                nxt_state.rdata[`CMP_BIT_PORT_D_MSB:`CMP_BIT_PORT_D_LSB] =
                    state_ff.pd_s2 & ~state_ff.analog;
                nxt_state.rdata[`CMP_BIT_PE_DIR_MSB:`CMP_BIT_PE_DIR_LSB] =
                    state_ff.pe_dir;
                nxt_state.rdata[`CMP_BIT_PE_LAT_MSB:`CMP_BIT_PE_LAT_LSB] =
                    state_ff.pe_lat;
            end
        end
        if (wr && sel == 2'h1) begin
            nxt_state.ctrl = 6'(pwdata[7:0] & `CMP_CTRL_RW_MASK);
        end
        if (wr && sel == 2'h2) begin
            nxt_state.irq_en = pwdata[`CMP_BIT_IRQ_EN];
            nxt_state.route_en = pwdata[`CMP_BIT_ROUTE_EN];
        end
        if (wr && sel == 2'h3) begin
            nxt_state.pe_dir =
                pwdata[`CMP_BIT_PE_DIR_MSB:`CMP_BIT_PE_DIR_LSB];
            nxt_state.pe_lat =
                pwdata[`CMP_BIT_PE_LAT_MSB:`CMP_BIT_PE_LAT_LSB];
        end
        // Registered so the enable pins never glitch on a decode
        nxt_state.oe = ~nxt_state.pe_dir;
        // Only a written zero clears; a change in the same cycle wins
        if (wr && sel == 2'h2) begin
            nxt_state.flag = pwdata[`CMP_BIT_FLAG];
        end
        if (chg_one || chg_two) begin
            nxt_state.flag = 1'b1;
        end
        next_ctrl = nxt_state.ctrl;
        next_mode = cmp_pkg::cmp_mode_type'(
            next_ctrl[`CMP_MODE_MSB:`CMP_MODE_LSB]);
        nxt_state.pwr_one = (next_mode != cmp_pkg::MODE_OFF)
            && (next_mode != cmp_pkg::MODE_RESET);
        nxt_state.pwr_two = nxt_state.pwr_one;
        nxt_state.ref_pos = (next_mode == cmp_pkg::MODE_INTERNAL_REF);
        nxt_state.neg_sw = (next_mode == cmp_pkg::MODE_INTERNAL_REF)
            && next_ctrl[`CMP_BIT_NEG_SWITCH];
        // Mode 111 releases the pins to digital use
        nxt_state.analog = (next_mode == cmp_pkg::MODE_OFF) ? 4'h0
                                                           : 4'hf;
        // No sleep input: the channels keep running regardless
        nxt_state.wake = nxt_state.flag && nxt_state.irq_en;
    end

    // Reset loads the defaults; otherwise the next state is taken each clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= '0;
            state_ff.ctrl <= 6'(`CMP_CTRL_RESET);
            state_ff.pe_dir <= `CMP_PE_DIR_RESET;
            state_ff.oe <= ~`CMP_PE_DIR_RESET;
            state_ff.analog <= 4'hf;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign prdata = state_ff.rdata;
    assign pready = state_ff.ready;
    assign pslverr = state_ff.err;
    assign cmp_one_power = state_ff.pwr_one;
    assign cmp_two_power = state_ff.pwr_two;
    assign ref_to_positive = state_ff.ref_pos;
    assign negative_input_switch = state_ff.neg_sw;
    assign port_d_analog = state_ff.analog;
    assign cmp_wake_irq = state_ff.wake;
    assign port_e_out = state_ff.route_en ? routed : state_ff.pe_lat;
    assign port_e_oe = state_ff.oe;

endmodule

`default_nettype wire

// ==== verilog/cmp_defs.svh ====
// Register offsets, field positions and reset values for the comparator block
`ifndef CMP_DEFS_SVH
`define CMP_DEFS_SVH

`define CMP_OFS_CONTROL 8'h00
`define CMP_OFS_FLAGS 8'h04
`define CMP_OFS_PORT 8'h08

`define CMP_CTRL_RESET 8'h00
`define CMP_CTRL_RW_MASK 8'h3f
`define CMP_BIT_TWO_RESULT 7
`define CMP_BIT_ONE_RESULT 6
`define CMP_BIT_TWO_POL 5
`define CMP_BIT_ONE_POL 4
`define CMP_BIT_NEG_SWITCH 3
`define CMP_MODE_MSB 2
`define CMP_MODE_LSB 0

`define CMP_BIT_FLAG 0
`define CMP_BIT_IRQ_EN 1
`define CMP_BIT_ROUTE_EN 2

`define CMP_BIT_PORT_D_LSB 0
`define CMP_BIT_PORT_D_MSB 3
`define CMP_BIT_PE_DIR_LSB 4
`define CMP_BIT_PE_DIR_MSB 5
`define CMP_BIT_PE_LAT_LSB 6
`define CMP_BIT_PE_LAT_MSB 7
`define CMP_PE_DIR_RESET 2'h3

`endif

// ==== verilog/cmp_pkg.sv ====
// Types shared by the comparator control block
package cmp_pkg;

    typedef enum logic [2:0] {
        MODE_RESET = 3'h0,
        MODE_ONE = 3'h1,
        MODE_TWO = 3'h2,
        MODE_THREE = 3'h3,
        MODE_FOUR = 3'h4,
        MODE_FIVE = 3'h5,
        MODE_INTERNAL_REF = 3'h6,
        MODE_OFF = 3'h7
    } cmp_mode_type;

    typedef struct packed {
        logic stage_one;
        logic stage_two;
        logic last;
        logic result;
        logic change;
    } sync_state_type;

endpackage

// ==== verilog/cmp_sync_chan.sv ====
// One comparator channel: synchroniser, polarity and change detection
`timescale 1ns/1ps
`default_nettype none

module cmp_sync_chan (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Channel
    input wire logic raw_out,
    input wire logic polarity,
    input wire logic active,
    output logic result,
    output logic change
);

    cmp_pkg::sync_state_type state_ff;
    cmp_pkg::sync_state_type nxt_state;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.stage_one = raw_out;
        nxt_state.stage_two = state_ff.stage_one;
        nxt_state.last = state_ff.stage_two;
        nxt_state.result = state_ff.stage_two ^ polarity;
        // Edge on the raw level so a polarity write alone never flags
        nxt_state.change = active
            && (state_ff.stage_two != state_ff.last);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign result = state_ff.result;
    assign change = state_ff.change;

endmodule

`default_nettype wire

// ==== bench/cmp_chk.sv ====
// Assertion checker for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module cmp_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // Comparator side
    input wire logic cmp_one_power,
    input wire logic cmp_two_power,
    input wire logic ref_to_positive,
    input wire logic negative_input_switch,
    input wire logic [3:0] port_d_analog
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    AST_RDY: assert property (psel && !penable |=> pready)
        else $error("no access cycle after setup");
    AST_ONE: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    AST_REF: assert property (ref_to_positive |-> cmp_one_power)
        else $error("reference applied to an unpowered comparator");
    AST_SW: assert property (negative_input_switch |-> ref_to_positive)
        else $error("input switch active outside mode 110");
    AST_OFF: assert property (port_d_analog == 4'h0 |-> !cmp_two_power)
        else $error("comparator powered with pins digital");
    AST_PAIR: assert property (cmp_one_power == cmp_two_power)
        else $error("comparator powers disagree");
    AST_ANA: assert property (port_d_analog inside {4'h0, 4'hf})
        else $error("partial analog pin map");
    AST_RST: assert property (!$past(presetn) |-> !cmp_one_power)
        else $error("comparator powered right after reset");
endmodule
bind dual_comparator_control cmp_chk u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready),
    .cmp_one_power(cmp_one_power), .cmp_two_power(cmp_two_power),
    .ref_to_positive(ref_to_positive),
    .negative_input_switch(negative_input_switch),
    .port_d_analog(port_d_analog));
`default_nettype wire

// ==== bench/cmp_analog_model.sv ====
// Behavioural model of the two analog comparator cells and input muxes
`timescale 1ns/1ps
`default_nettype none
module cmp_analog_model (
    // Mux controls
    input wire logic ref_on,
    input wire logic sw,
    // Levels: 0..3 port D lines, 4 and 5 positive pins
    input wire logic [7:0] vref,
    input wire logic [5:0][7:0] vin,
    // Raw results
    output logic one_raw,
    output logic two_raw
);
    // Equal levels resolve low; real cells are uncertain there
    assign one_raw = (ref_on ? vref : vin[4])
        > (sw ? vin[0] : vin[1]);
    assign two_raw = (ref_on ? vref : vin[5])
        > (sw ? vin[2] : vin[3]);
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking testbench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic one_raw, two_raw, one_pwr, two_pwr, ref_on, sw, wake;
    logic [3:0] pins, analog;
    logic [1:0] e_out, e_oe;
    logic [5:0][7:0] vin;
    logic [32:0] expq[$];
    int mismatches, comparisons, seed;
    dual_comparator_control uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp_one_raw(one_raw), .cmp_two_raw(two_raw),
        .cmp_one_power(one_pwr), .cmp_two_power(two_pwr),
        .ref_to_positive(ref_on), .negative_input_switch(sw),
        .port_d_pins(pins), .port_d_analog(analog), .port_e_out(e_out),
        .port_e_oe(e_oe), .cmp_wake_irq(wake));
    cmp_analog_model m_ana (.ref_on(ref_on), .sw(sw), .vref(8'h80),
        .vin(vin), .one_raw(one_raw), .two_raw(two_raw));
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [32:0] e, g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees ready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // Expected word goes in before the request, error flag on top
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        expq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (expq.size() == 0) chk("queue", 33'h0, 33'h1);
            else chk("prdata", expq.pop_front(), {pslverr, prdata});
        end
    end
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        #100000;
        mismatches++;
        final_report;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        seed = 28814;
        pins = 4'($random(seed));
        // Lines 0/2 above the reference, lines 1/3 below
        vin = {8'h0a, 8'h0a, 8'h32, 8'hc8, 8'h32, 8'hc8};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00, 33'h0);
        rd(8'h04, 33'h0);
        for (int m = 0; m < 8; m++) begin
            wr(8'h00, 32'(m));
            tick(2);
            chk("power", 33'(m != 0 && m != 7), 33'(one_pwr));
            chk("power two", 33'(m != 0 && m != 7), 33'(two_pwr));
            chk("ref", 33'(m == 6), 33'(ref_on));
            chk("analog", 33'(m == 7 ? 4'h0 : 4'hf), 33'(analog));
            rd(8'h08, 33'(8'h30 | (m == 7 ? pins : 4'h0)));
        end
        wr(8'h04, 32'h0);
        wr(8'h00, 32'hce);
        tick(4);
        rd(8'h00, 33'h0e);
        chk("switch", 33'h1, 33'(sw));
        wr(8'h04, 32'h2);
        rd(8'h04, 33'h2);
        wr(8'h00, 32'h06);
        tick(6);
        rd(8'h00, 33'hc6);
        rd(8'h04, 33'h3);
        chk("wake", 33'h1, 33'(wake));
        wr(8'h00, 32'h36);
        tick(4);
        rd(8'h00, 33'h36);
        rd(8'h04, 33'h3);
        wr(8'h04, 32'h2);
        rd(8'h04, 33'h2);
        chk("wake", 33'h0, 33'(wake));
        wr(8'h00, 32'h07);
        vin[4] <= 8'hff;
        tick(6);
        rd(8'h04, 33'h2);
        wr(8'h04, 32'h4);
        wr(8'h08, 32'h90);
        tick(2);
        chk("oe", 33'h2, 33'(e_oe));
        chk("route", 33'h1, 33'(e_out));
        // No clock edge between: routed path must be unsynchronised
        vin[4] <= 8'h00;
        #1;
        chk("route", 33'h0, 33'(e_out));
        wr(8'h04, 32'h0);
        tick(2);
        chk("latch", 33'h2, 33'(e_out));
        rd(8'h08, 33'(8'h90 | pins));
        rd(8'h0c, {1'b1, 32'h0});
        wr(8'h0c, 32'hff);
        rd(8'h00, 33'h07);
        final_report;
    end
endmodule
`default_nettype wire
